// ### src/gpio_cfg_regs.svh
// Purpose: Offsets, indices and reset values for the port configuration block.
// Assumes: One eight-bit bus access per cycle, ports A to D.
// Notes: Included by the package and the design file.
`ifndef GPIO_CFG_REGS_SVH
`define GPIO_CFG_REGS_SVH
`define PORT_ADDR_OFS 8'h00
`define PORT_CTRL_OFS 8'h01
`define IDX_ALT_ENABLE 8'h02
`define IDX_DRAIN_CTRL 8'h03
`define ALT_EN_RST_ABC 8'h00
`define ALT_EN_RST_D 8'h01
`define DRAIN_RST 8'h00
`define PORT_D_NUM 2'h3
`define NUM_PORTS 4
`endif

// ### src/gpio_cfg_pkg.sv
// Purpose: Types shared by the port configuration block.
// Assumes: Constants come from the register header.
// Notes: Holds types only.
`include "gpio_cfg_regs.svh"
package gpio_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    byte_t [`NUM_PORTS-1:0] port_index;
    byte_t [`NUM_PORTS-1:0] alt_function_enable_sub;
    byte_t [`NUM_PORTS-1:0] drain_control_sub;
    byte_t rd_data;
    logic [`NUM_PORTS-1:0][7:0] pin_oe;
    logic [`NUM_PORTS-1:0][7:0] pin_out;
  } cfg_state_t;
endpackage : gpio_cfg_pkg

// ### src/gpio_altfunc_opendrain_cfg.sv
// Purpose: Alternate-function enable and open-drain control for ports A to D.
// Assumes: The direction, output data and set bytes live elsewhere and come in as inputs,
//          as do the alternate functions' drive values and enables.
// Notes: Pin outputs are registered, so pins follow settings one cycle late.
//        Open drain only stops the high drive; a low level is still sunk by the pin.
//        Nothing here stops software from enabling a pin that has no alternate function,
//        so that guard stays with the software.
`timescale 1ns/1ps
`include "gpio_cfg_regs.svh"
module gpio_altfunc_opendrain_cfg
  import gpio_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] bus_port,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [`NUM_PORTS-1:0][7:0] pin_direction_bit,
  input wire logic [`NUM_PORTS-1:0][7:0] gpio_out_data,
  input wire logic [`NUM_PORTS-1:0][7:0] alt_set1,
  input wire logic [`NUM_PORTS-1:0][7:0] alt_set2,
  input wire logic [`NUM_PORTS-1:0][3:0][7:0] alt_out_data,
  input wire logic [`NUM_PORTS-1:0][3:0][7:0] alt_out_en,
  output logic [`NUM_PORTS-1:0][7:0] pin_out,
  output logic [`NUM_PORTS-1:0][7:0] pin_oe
);

  cfg_state_t cur_ff;
  cfg_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] fsel;
    logic drive;
    logic level;
    nxt_state = cur_ff;
    fsel = 2'h0;
    drive = 1'b0;
    level = 1'b0;
    // A control access in the same cycle as an index write still sees the old index, so
    // software lets the index write land first.
    if (bus_wr && bus_addr == `PORT_ADDR_OFS) begin
      nxt_state.port_index[bus_port] = bus_wdata;
    end
    if (bus_wr && bus_addr == `PORT_CTRL_OFS) begin
      if (cur_ff.port_index[bus_port] == `IDX_ALT_ENABLE) begin
        nxt_state.alt_function_enable_sub[bus_port] = bus_wdata;
      end
      if (cur_ff.port_index[bus_port] == `IDX_DRAIN_CTRL) begin
        nxt_state.drain_control_sub[bus_port] = bus_wdata;
      end
    end
    // The read byte is registered and held until the next read; other indices read zero.
    if (bus_rd) begin
      nxt_state.rd_data = 8'h00;
      if (bus_addr == `PORT_ADDR_OFS) begin
        nxt_state.rd_data = cur_ff.port_index[bus_port];
      end else if (bus_addr == `PORT_CTRL_OFS) begin
        if (cur_ff.port_index[bus_port] == `IDX_ALT_ENABLE) begin
          nxt_state.rd_data = cur_ff.alt_function_enable_sub[bus_port];
        end else if (cur_ff.port_index[bus_port] == `IDX_DRAIN_CTRL) begin
          nxt_state.rd_data = cur_ff.drain_control_sub[bus_port];
        end
      end
    end
    // Open drain acts after the function mux, so alternate functions are bound by it too.
    // Each pin n of each port is handled by bit n of every byte.
    for (int p = 0; p < `NUM_PORTS; p++) begin
      for (int n = 0; n < 8; n++) begin
        fsel = {alt_set2[p][n], alt_set1[p][n]};
        if (cur_ff.alt_function_enable_sub[p][n]) begin
          drive = alt_out_en[p][fsel][n];
          level = alt_out_data[p][fsel][n];
        end else begin
          drive = pin_direction_bit[p][n] == 1'b0;
          level = gpio_out_data[p][n];
        end
        // Open drain only lets the pin pull low; a high is left to the pull-up.
        if (cur_ff.drain_control_sub[p][n] && level) begin
          drive = 1'b0;
        end
        nxt_state.pin_oe[p][n] = drive;
        nxt_state.pin_out[p][n] = level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
      // Port D leaves reset with pin 0 already handed to its alternate function.
      for (int p = 0; p < `NUM_PORTS; p++) begin
        cur_ff.alt_function_enable_sub[p] <= (p == `PORT_D_NUM) ? `ALT_EN_RST_D
                                                                 : `ALT_EN_RST_ABC;
        cur_ff.drain_control_sub[p] <= `DRAIN_RST;
      end
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign bus_rdata = cur_ff.rd_data;
  assign pin_oe = cur_ff.pin_oe;
  assign pin_out = cur_ff.pin_out;

  ////////////////////////////////////////////////////////////////////////////////
  a_alt_write_idx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_wr && bus_addr == `PORT_CTRL_OFS && cur_ff.port_index[bus_port] == `IDX_ALT_ENABLE
    |=> cur_ff.alt_function_enable_sub[$past(bus_port)] == $past(bus_wdata))
    else $error("Alternate enable write lost.");
  a_alt_hold_idx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(bus_wr && bus_addr == `PORT_CTRL_OFS) |=> $stable(cur_ff.alt_function_enable_sub))
    else $error("Alternate enable changed without a write.");
  a_drain_write_idx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_wr && bus_addr == `PORT_CTRL_OFS && cur_ff.port_index[bus_port] == `IDX_DRAIN_CTRL
    |=> cur_ff.drain_control_sub[$past(bus_port)] == $past(bus_wdata))
    else $error("Drain control write lost.");
  a_drain_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(bus_wr && bus_addr == `PORT_CTRL_OFS) |=> $stable(cur_ff.drain_control_sub))
    else $error("Drain control changed without a write.");
  a_gpio_dir_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
    && !cur_ff.alt_function_enable_sub[0][0] && !cur_ff.drain_control_sub[0][0]
    && $stable(cur_ff.alt_function_enable_sub) && $stable(cur_ff.drain_control_sub)
    |-> pin_oe[0][0] == !$past(pin_direction_bit[0][0]))
    else $error("GPIO pin direction wrong.");
  a_open_drain_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_out & pin_oe & $past(cur_ff.drain_control_sub)) == '0)
    else $error("Open drain pin drove high.");
  a_alt_func_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cur_ff.alt_function_enable_sub[2][5] && !cur_ff.drain_control_sub[2][5]
    |=> pin_oe[2][5] == $past(alt_out_en[2][{alt_set2[2][5], alt_set1[2][5]}][5])
    && pin_out[2][5] == $past(alt_out_data[2][{alt_set2[2][5], alt_set1[2][5]}][5]))
    else $error("Alternate function not driving pin.");
  a_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_rd && bus_addr == `PORT_CTRL_OFS && cur_ff.port_index[bus_port] == `IDX_ALT_ENABLE
    |=> bus_rdata == $past(cur_ff.alt_function_enable_sub[bus_port]))
    else $error("Read back mismatch.");

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values are checked at the first edge right after release, before any bus access.
  a_reset_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> cur_ff.alt_function_enable_sub
      == {`ALT_EN_RST_D, `ALT_EN_RST_ABC, `ALT_EN_RST_ABC, `ALT_EN_RST_ABC})
    else $error("Enable byte reset value wrong.");
  a_reset_drain: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> cur_ff.drain_control_sub == {`NUM_PORTS{`DRAIN_RST}})
    else $error("Drain byte reset value wrong.");

  ////////////////////////////////////////////////////////////////////////////////
  // Bus side: the index register takes every write to its offset and reads back as written.
  a_index_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_wr && bus_addr == `PORT_ADDR_OFS
    |=> cur_ff.port_index[$past(bus_port)] == $past(bus_wdata))
    else $error("Index write lost.");
  a_index_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(bus_wr && bus_addr == `PORT_ADDR_OFS) |=> $stable(cur_ff.port_index))
    else $error("Index changed without a write.");
  a_index_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_rd && bus_addr == `PORT_ADDR_OFS
    |=> bus_rdata == $past(cur_ff.port_index[bus_port]))
    else $error("Index read back mismatch.");
  // A control access at an index that names neither byte must change nothing and read zero.
  a_bad_index_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_wr && bus_addr == `PORT_CTRL_OFS
    && cur_ff.port_index[bus_port] != `IDX_ALT_ENABLE
    && cur_ff.port_index[bus_port] != `IDX_DRAIN_CTRL
    |=> $stable(cur_ff.alt_function_enable_sub) && $stable(cur_ff.drain_control_sub))
    else $error("Write at an unused index changed a byte.");
  a_refused_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_rd && bus_addr == `PORT_CTRL_OFS
    && cur_ff.port_index[bus_port] != `IDX_ALT_ENABLE
    && cur_ff.port_index[bus_port] != `IDX_DRAIN_CTRL
    |=> bus_rdata == 8'h00)
    else $error("Read at an unused index returned data.");
  a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_rd && bus_addr != `PORT_ADDR_OFS && bus_addr != `PORT_CTRL_OFS
    |=> bus_rdata == 8'h00)
    else $error("Read at an unmapped offset returned data.");
  a_drain_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_rd && bus_addr == `PORT_CTRL_OFS && cur_ff.port_index[bus_port] == `IDX_DRAIN_CTRL
    |=> bus_rdata == $past(cur_ff.drain_control_sub[bus_port]))
    else $error("Drain read back mismatch.");
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !bus_rd |=> $stable(bus_rdata))
    else $error("Read data changed without a read.");

  ////////////////////////////////////////////////////////////////////////////////
  // Pin side, all pins at once. Pin flops lag their inputs by one edge, so settings and
  // inputs are taken one edge back, and the first edge after reset is skipped.
  a_gpio_dir_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> ((pin_oe ^ ~$past(pin_direction_bit))
      & ~$past(cur_ff.alt_function_enable_sub) & ~$past(cur_ff.drain_control_sub)) == '0)
    else $error("GPIO pin enable does not follow its direction bit.");
  a_gpio_level_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> ((pin_out ^ $past(gpio_out_data))
      & ~$past(cur_ff.alt_function_enable_sub)) == '0)
    else $error("GPIO pin level does not follow its output data.");
  a_drain_sinks_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> (~pin_oe & ~pin_out & ~$past(pin_direction_bit)
      & ~$past(cur_ff.alt_function_enable_sub)) == '0)
    else $error("Output pin stopped sinking a low level.");

endmodule : gpio_altfunc_opendrain_cfg

// ### tb/gpio_altfunc_opendrain_cfg_tb.sv
// Purpose: Self-checking bench for the alternate-function and open-drain block.
// Assumes: Index write at offset 00h, then control access at 01h, per port.
// Notes: Pin outputs are compared once their inputs have been still for two edges.
`timescale 1ns/1ps
`include "gpio_cfg_regs.svh"
module gpio_altfunc_opendrain_cfg_tb;
  import gpio_cfg_pkg::*;
  typedef struct {logic [1:0] p; byte_t idx, wd, ex;} row_t;
  logic sys_clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0;
  logic [1:0] bus_port = 0;
  byte_t bus_addr = 0, bus_wdata = 0, bus_rdata;
  logic [3:0][7:0] dir, gdat, s1, s2, pin_out, pin_oe, en_m, dr_m;
  logic [3:0][3:0][7:0] adat, aen;
  logic [15:0] oe_out;
  int miscompares = 0, checked = 0;
  // Every pin has all four functions wired up here, so any enable pattern is legal.
  row_t rows[7] = '{'{2'h0, 8'h02, 8'h0F, 8'h0F}, '{2'h0, 8'h03, 8'h33, 8'h33},
    '{2'h1, 8'h02, 8'hF0, 8'hF0}, '{2'h1, 8'h03, 8'hFF, 8'hFF},
    '{2'h2, 8'h04, 8'h77, 8'h00}, '{2'h3, 8'h03, 8'h5A, 8'h5A},
    '{2'h2, 8'h02, 8'hFF, 8'hFF}};
  gpio_altfunc_opendrain_cfg gpio_altfunc_opendrain_cfg_i (.sys_clk, .rst_n, .bus_port,
    .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .pin_direction_bit(dir),
    .gpio_out_data(gdat), .alt_set1(s1), .alt_set2(s2), .alt_out_data(adat),
    .alt_out_en(aen), .pin_out, .pin_oe);
  always #5 sys_clk = ~sys_clk;
  // The whole run needs well under a thousand cycles, so this only trips on a hang.
  initial begin
    #20000;
    miscompares++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task acc(logic w, logic [1:0] p, byte_t a, byte_t d);
    @(posedge sys_clk);
    {bus_wr, bus_rd, bus_port, bus_addr, bus_wdata} <= {w, !w, p, a, d};
    @(posedge sys_clk);
    {bus_wr, bus_rd} <= 2'h0;
    #1;
  endtask : acc
  task final_report;
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Expected {out, oe} of one port, worked out bit by bit from the settings.
  function automatic logic [15:0] pins(int p);
    logic [7:0] o, e;
    logic [1:0] f;
    for (int n = 0; n < 8; n++) begin
      f = {s2[p][n], s1[p][n]};
      o[n] = en_m[p][n] ? adat[p][f][n] : gdat[p][n];
      e[n] = en_m[p][n] ? aen[p][f][n] : !dir[p][n];
      if (dr_m[p][n] && o[n]) e[n] = 1'b0;
    end
    return {o, e};
  endfunction : pins
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 16; i++) begin
      adat[i / 4][i % 4] = 8'h11 * i;
      aen[i / 4][i % 4] = 8'hC3 ^ (8'h11 * i);
    end
    {dir, gdat, s1, s2} = {{4{8'hF0}}, {4{8'hA5}}, {4{8'h0A}}, {4{8'h0C}}};
    {en_m, dr_m} = {8'h01, 24'h00_0000, 32'h0000_0000};
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      acc(1'b1, 2'(p), 8'h00, 8'h02);
      acc(1'b0, 2'(p), 8'h01, 8'h00);
      chk("reset enable", bus_rdata, (p == 3) ? 8'h01 : 8'h00);
      acc(1'b1, 2'(p), 8'h00, 8'h03);
      acc(1'b0, 2'(p), 8'h01, 8'h00);
      chk("reset drain", bus_rdata, 8'h00);
    end
    foreach (rows[i]) begin
      acc(1'b1, rows[i].p, 8'h00, rows[i].idx);
      acc(1'b1, rows[i].p, 8'h01, rows[i].wd);
      acc(1'b0, rows[i].p, 8'h01, 8'h00);
      chk("readback", bus_rdata, rows[i].ex);
      if (rows[i].idx == 8'h02) en_m[rows[i].p] = rows[i].wd;
      if (rows[i].idx == 8'h03) dr_m[rows[i].p] = rows[i].wd;
    end
    acc(1'b0, 2'h1, 8'h00, 8'h00);
    chk("index", bus_rdata, 8'h03);
    acc(1'b0, 2'h0, 8'h07, 8'h00);
    chk("unmapped", bus_rdata, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    for (int p = 0; p < 4; p++) begin
      oe_out = pins(p);
      chk("pin_oe", pin_oe[p], oe_out[7:0]);
      chk("pin_out", pin_out[p] & oe_out[7:0], oe_out[15:8] & oe_out[7:0]);
    end
    // A reset in mid-run must bring port 3's enable byte and port 1's drain byte back to their reset values.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(1'b1, 2'h3, 8'h00, 8'h02);
    acc(1'b0, 2'h3, 8'h01, 8'h00);
    chk("mid reset enable", bus_rdata, 8'h01);
    acc(1'b1, 2'h1, 8'h00, 8'h03);
    acc(1'b0, 2'h1, 8'h01, 8'h00);
    chk("mid reset drain", bus_rdata, 8'h00);
    final_report();
  end
endmodule : gpio_altfunc_opendrain_cfg_tb
